// [common/hscp_edge_if.sv]
// Interface carrying sampled pin events between the port modules.
`timescale 1ns/10ps
interface hscp_edge_if;
	logic rise;     // Serial clock rising edge seen while selected.
	logic fall;     // Serial clock falling edge seen while selected.
	logic data;     // Command line value at the rising edge.
	logic sel_on;   // Select line has just gone low.
	logic sel_off;  // Select line has just gone high.
	logic selected; // Select line is low.
	modport src (output rise, fall, data, sel_on, sel_off, selected);
	modport dst (input  rise, fall, data, sel_on, sel_off, selected);
endinterface

// [common/hscp_pkg.sv]
// Package with constants and types of the host serial control port.
package hscp_pkg;
	// =====================================================================
	// Clock and timing
	// =====================================================================
	localparam int CLK_PERIOD_NS  = 50;   // System clock period in ns.
	localparam int HIZ_MAX_NS     = 1000; // Longest select-high to float.
	// Longest time rounds down, never below one cycle.
	localparam int HIZ_CYCLES = (HIZ_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(HIZ_MAX_NS / CLK_PERIOD_NS);
	// =====================================================================
	// Field layout
	// =====================================================================
	localparam int BYTE_W    = 8; // Width of a command or reply byte.
	localparam int MSB_POS   = 7; // First bit on the wire.
	localparam int CNT_W     = 5; // Width of the received bit counter.
	localparam int ONE_BYTE  = 8; // Bits in a one-byte command.
	localparam int TWO_BYTE  = 16; // Bits in a two-byte command.
	localparam logic [15:0] CMD_RESET = 16'h0000; // Command reset value.
	localparam logic [7:0]  BYTE_RESET = 8'h00;   // Reply reset value.
	// Transaction state, one-hot.
	typedef enum logic [2:0] {
		HSCP_IDLE = 3'b001,
		HSCP_BUSY = 3'b010,
		HSCP_DONE = 3'b100
	} hscp_state_e;
endpackage

// [rtl/hscp_edge.sv]
// Edge detector for the serial clock and select pins.
`timescale 1ns/10ps
module hscp_edge (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic sclk_line,
	input  wire logic select_n_line,
	input  wire logic cmd_line,
	hscp_edge_if.src  ev
);
	logic sclk_reg;  // Last seen serial clock level.
	logic sclk_next; // Next serial clock level.
	logic seln_reg;  // Last seen select level.
	logic seln_next; // Next select level.

	// =====================================================================
	// Edge computation
	// =====================================================================
	// Comparing against the previous level makes the idle polarity of the
	// serial clock irrelevant: an idle level produces no edge at all.
	always_comb begin
		sclk_next   = sclk_line;
		seln_next   = select_n_line;
		ev.rise     = sclk_line & ~sclk_reg & ~select_n_line;
		ev.fall     = ~sclk_line & sclk_reg & ~select_n_line;
		ev.data     = cmd_line;
		ev.sel_on   = ~select_n_line & seln_reg;
		ev.sel_off  = select_n_line & ~seln_reg;
		ev.selected = ~select_n_line;
	end

	// Registers only hold the last levels; select idles high.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_reg <= 1'b0;
			seln_reg <= 1'b1;
		end else begin
			sclk_reg <= sclk_next;
			seln_reg <= seln_next;
		end
	end
endmodule

// [rtl/hscp_port.sv]
// Top of the host serial control port: command shift and reply shift.
`timescale 1ns/10ps
module hscp_port (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        sclk_line,
	input  wire logic        select_n_line,
	input  wire logic        cmd_line,
	input  wire logic [7:0]  reply_byte,
	output logic             reply_take,
	output logic             reply_out_line,
	output logic             reply_oe_n,
	output logic             cmd_valid,
	output logic             cmd_two,
	output logic [15:0]      cmd_word
);
	// =====================================================================
	// Declarations
	// =====================================================================
	hscp_edge_if ev ();                   // Pin events from the detector.
	hscp_pkg::hscp_state_e state_reg;     // Transaction state.
	hscp_pkg::hscp_state_e state_next;    // Next transaction state.
	logic [15:0] shift_reg;               // Incoming command bits.
	logic [15:0] shift_next;              // Next incoming command bits.
	logic [4:0]  count_reg;               // Command bits received.
	logic [4:0]  count_next;              // Next command bit count.
	logic [7:0]  rsh_reg;                 // Reply shift register.
	logic [7:0]  rsh_next;                // Next reply shift register.
	logic [2:0]  rbit_reg;                // Reply bits already sent.
	logic [2:0]  rbit_next;               // Next reply bit index.
	logic        out_reg;                 // Reply pin value.
	logic        out_next;                // Next reply pin value.
	logic        oen_reg;                 // Reply enable, low drives.
	logic        oen_next;                // Next reply enable.
	logic        take_reg;                // Reply byte consumed pulse.
	logic        take_next;               // Next consumed pulse.
	logic        valid_reg;               // Command done pulse.
	logic        valid_next;              // Next command done pulse.
	logic        two_reg;                 // Command had two bytes.
	logic        two_next;                // Next two-byte flag.
	logic [15:0] word_reg;                // Executed command word.
	logic [15:0] word_next;               // Next command word.

	hscp_edge u_edge (
		.clk           (clk),
		.rst_b         (rst_b),
		.sclk_line     (sclk_line),
		.select_n_line (select_n_line),
		.cmd_line      (cmd_line),
		.ev            (ev)
	);

	// Saturating increment used by the command bit counter.
	function automatic logic [4:0] hscp_inc(input logic [4:0] v);
		hscp_inc = (v == 5'h1F) ? v : v + 5'h01;
	endfunction

	// =====================================================================
	// Command side
	// =====================================================================
	// Bits shift in at the bottom so that the first bit ends up highest.
	// Nothing is handed on until select goes high; a transfer that ends
	// on any count other than one or two whole bytes is dropped without a completion pulse.
	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		count_next = count_reg;
		valid_next = 1'b0;
		two_next   = two_reg;
		word_next  = word_reg;
		case (state_reg)
			hscp_pkg::HSCP_IDLE: begin
				if (ev.selected) begin
					state_next = hscp_pkg::HSCP_BUSY;
					shift_next = hscp_pkg::CMD_RESET;
					count_next = 5'h00;
				end
			end
			hscp_pkg::HSCP_BUSY: begin
				if (ev.rise) begin
					shift_next = {shift_reg[14:0], ev.data};
					count_next = hscp_inc(count_reg);
				end
				if (ev.sel_off) begin
					state_next = hscp_pkg::HSCP_DONE;
				end
			end
			hscp_pkg::HSCP_DONE: begin
				// Only counts of exactly one or two bytes are executed.
				state_next = hscp_pkg::HSCP_IDLE;
				if (count_reg == 5'(hscp_pkg::ONE_BYTE)) begin
					valid_next = 1'b1;
					two_next   = 1'b0;
					word_next  = {8'h00, shift_reg[7:0]};
				end else if (count_reg == 5'(hscp_pkg::TWO_BYTE)) begin
					valid_next = 1'b1;
					two_next   = 1'b1;
					word_next  = shift_reg;
				end
			end
			default: begin
				state_next = hscp_pkg::HSCP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= hscp_pkg::HSCP_IDLE;
			shift_reg <= hscp_pkg::CMD_RESET;
			count_reg <= 5'h00;
			valid_reg <= 1'b0;
			two_reg   <= 1'b0;
			word_reg  <= hscp_pkg::CMD_RESET;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			count_reg <= count_next;
			valid_reg <= valid_next;
			two_reg   <= two_next;
			word_reg  <= word_next;
		end
	end

	// =====================================================================
	// Reply side
	// =====================================================================
	// The first falling edge loads the reply byte and drives its MSB; each
	// later falling edge moves one bit on, so the host sees a stable bit
	// at its next rising edge. Release happens one cycle after select
	// rises, far inside the allowed float time.
	always_comb begin
		rsh_next  = rsh_reg;
		rbit_next = rbit_reg;
		out_next  = out_reg;
		oen_next  = oen_reg;
		take_next = 1'b0;
		if (!ev.selected) begin
			oen_next  = 1'b1;
			rbit_next = 3'h0;
		end else if (ev.fall) begin
			oen_next = 1'b0;
			if (rbit_reg == 3'h0) begin
				rsh_next  = {reply_byte[6:0], 1'b0};
				out_next  = reply_byte[hscp_pkg::MSB_POS];
				take_next = 1'b1;
			end else begin
				rsh_next = {rsh_reg[6:0], 1'b0};
				out_next = rsh_reg[hscp_pkg::MSB_POS];
			end
			rbit_next = rbit_reg + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rsh_reg  <= hscp_pkg::BYTE_RESET;
			rbit_reg <= 3'h0;
			out_reg  <= 1'b0;
			oen_reg  <= 1'b1;
			take_reg <= 1'b0;
		end else begin
			rsh_reg  <= rsh_next;
			rbit_reg <= rbit_next;
			out_reg  <= out_next;
			oen_reg  <= oen_next;
			take_reg <= take_next;
		end
	end

	assign reply_out_line = out_reg;
	assign reply_oe_n     = oen_reg;
	assign reply_take     = take_reg;
	assign cmd_valid      = valid_reg;
	assign cmd_two        = two_reg;
	assign cmd_word       = word_reg;

	// =====================================================================
	// Assertions
	// =====================================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_EXEC_AT_END: assert property (
		cmd_valid |-> $past(select_n_line, 2) && !$past(select_n_line, 3))
		else $error("command executed while still selected");
	AST_NO_EXEC_SEL: assert property (
		!select_n_line ##1 !select_n_line |-> !cmd_valid)
		else $error("command pulse during transaction");
	AST_HIZ_BOUND: assert property (
		$rose(select_n_line) |-> ##[1:20] reply_oe_n)
		else $error("reply not released in time");
	AST_HIZ_HOLD: assert property (
		select_n_line ##1 select_n_line |-> reply_oe_n)
		else $error("reply driven while deselected");
	AST_DRIVE_ON_FALL: assert property (
		$fell(reply_oe_n) |-> $past(ev.fall))
		else $error("reply enabled without falling edge");
	AST_BIT_ON_FALL: assert property (
		!reply_oe_n && $changed(reply_out_line) |-> $past(ev.fall))
		else $error("reply bit changed away from falling edge");
	AST_MSB_FIRST: assert property (
		ev.fall && ev.selected && rbit_reg == 3'h0 |=>
		reply_out_line == $past(reply_byte[7]))
		else $error("reply did not start with msb");
	AST_SAMPLE_RISE: assert property (
		ev.rise && state_reg == hscp_pkg::HSCP_BUSY && count_reg < 5'h1F
		|=> count_reg == $past(count_reg) + 5'h01 &&
		shift_reg[0] == $past(cmd_line))
		else $error("bit not sampled on rising edge");
	AST_TWO_FLAG: assert property (
		cmd_valid && cmd_two |-> $past(count_reg) == 5'h10)
		else $error("two-byte flag without sixteen bits");

	COV_ONE_BYTE: cover property (cmd_valid && !cmd_two);
	COV_TWO_BYTE: cover property (cmd_valid && cmd_two);
	COV_REPLY: cover property ($fell(reply_oe_n));
	COV_RELEASE: cover property ($rose(reply_oe_n));
endmodule

// [tb/hscp_host.sv]
// Host model that drives the select, serial clock and command pins.
`timescale 1ns/10ps
module hscp_host (
	input  wire logic clk,
	input  wire logic reply_out_line,
	input  wire logic reply_oe_n,
	output logic      sclk_line,
	output logic      select_n_line,
	output logic      cmd_line
);
	// =============================================================
	// Pin drive
	// =============================================================
	localparam int HALF = 6; // Serial clock phase in cycles.
	// All pins idle high or low at time zero.
	initial begin
		sclk_line = 1'b1;
		select_n_line = 1'b1;
		cmd_line = 1'b0;
	end
	// Clocks the bus while deselected; the port must ignore it.
	task automatic toggle(input int n);
		repeat (n) begin
			repeat (2) @(negedge clk);
			sclk_line = ~sclk_line;
		end
	endtask
	// One transaction; idle_hi picks the resting clock level.
	task automatic xfer(input logic [15:0] w, input int nb,
		input logic idle_hi, output logic [15:0] rx,
		output logic early);
		logic b;
		rx = 16'h0000;
		early = 1'b0;
		sclk_line = idle_hi;
		repeat (24) @(negedge clk);
		select_n_line = 1'b0;
		repeat (3) @(negedge clk);
		for (int i = nb - 1; i >= 0; i--) begin
			// Nothing may drive the reply before the first fall.
			if (idle_hi) begin
				early |= (i == nb - 1) && (reply_oe_n === 1'b0);
				sclk_line = 1'b0;
			end
			cmd_line = w[i];
			repeat (HALF) @(negedge clk);
			// A floating pin reads as the inverse of the last bit.
			b = (reply_oe_n === 1'b0) ? reply_out_line : ~rx[0];
			rx = {rx[14:0], b};
			sclk_line = 1'b1;
			repeat (4) @(negedge clk);
			// Past the hold time the line carries garbage.
			cmd_line = ~w[i];
			repeat (HALF - 4) @(negedge clk);
			if (!idle_hi) begin
				early |= (i == nb - 1) && (reply_oe_n === 1'b0);
				sclk_line = 1'b0;
				repeat (HALF) @(negedge clk);
			end
		end
		repeat (3) @(negedge clk);
		select_n_line = 1'b1;
	endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the host serial control port.
`timescale 1ns/10ps
module tb;
	// =============================================================
	// Signals
	// =============================================================
	logic        clk = 1'b0;          // 20 MHz system clock.
	logic        rst_b = 1'b0;        // Reset, held at start.
	logic        sclk_line;           // Host serial clock.
	logic        select_n_line;       // Host select.
	logic        cmd_line;            // Host command data.
	logic        reply_take;          // Reply byte loaded.
	logic        reply_out_line;      // Reply pin.
	logic        reply_oe_n;          // Reply drive enable.
	logic        cmd_valid;           // Command complete.
	logic        cmd_two;             // Two-byte command.
	logic [15:0] cmd_word;            // Last command.
	logic [7:0]  reply_byte = 8'h5A;  // Byte offered.
	logic [7:0]  ntake = 8'h00;       // Bytes loaded so far.
	logic [15:0] last = 16'h0000;     // Last accepted word.
	int          failures = 0;        // Mismatches.
	int          n_tests = 0;         // Comparisons.
	always #25 clk = ~clk;
	// Reply bytes follow a fixed series, so each load is known.
	function automatic logic [7:0] rb(input logic [7:0] n);
		return 8'h5A + 8'h33 * n;
	endfunction
	// Outputs are read at the falling edge, where they have settled.
	always @(negedge clk) if (reply_take === 1'b1) ntake <= ntake + 8'h01;
	always @(negedge clk) reply_byte <= rb(ntake);
	// A command that completes while selected is premature.
	always @(negedge clk)
		if (cmd_valid === 1'b1 && select_n_line === 1'b0)
			check(16'h0001, 16'h0000);
	hscp_port i_hscp_port (.clk(clk), .rst_b(rst_b),
		.sclk_line(sclk_line), .select_n_line(select_n_line),
		.cmd_line(cmd_line), .reply_byte(reply_byte),
		.reply_take(reply_take), .reply_out_line(reply_out_line),
		.reply_oe_n(reply_oe_n), .cmd_valid(cmd_valid),
		.cmd_two(cmd_two), .cmd_word(cmd_word));
	hscp_host i_hscp_host (.clk(clk), .reply_out_line(reply_out_line),
		.reply_oe_n(reply_oe_n), .sclk_line(sclk_line),
		.select_n_line(select_n_line), .cmd_line(cmd_line));
	// =============================================================
	// Shared tasks
	// =============================================================
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Bounded wait for a completion pulse, which lasts one cycle.
	task automatic wait_valid(input logic want);
		int i;
		for (i = 0; i < 8 && cmd_valid !== 1'b1; i++) @(negedge clk);
		check(16'(i < 8), 16'(want));
		if (want && i == 8)
			summarize;
		if (i < 8) begin
			@(negedge clk);
			check(16'(cmd_valid), 16'h0000);
		end
	endtask
	// One transaction and its judgement.
	task automatic run(input logic [15:0] w, input int nb, input logic hi);
		logic [15:0] rx;
		logic [15:0] ex;
		logic        early;
		logic        ok;
		logic [15:0] mask;
		ok = (nb == 8) || (nb == 16);
		// With a low idle clock the reply lags one bit behind the samples.
		mask = (nb == 8) ? 16'h007F : 16'h7FFF;
		if (ok)
			last = (nb == 8) ? {8'h00, w[7:0]} : w;
		ex = (nb == 8) ? {8'h00, rb(ntake)} : {rb(ntake), rb(ntake + 8'h01)};
		i_hscp_host.xfer(w, nb, hi, rx, early);
		wait_valid(ok);
		check(16'(early), 16'h0000);
		check(16'(reply_oe_n), 16'h0001);
		check(cmd_word, last);
		if (ok)
			check(16'(cmd_two), 16'(nb == 16));
		if (ok && hi)
			check(rx, ex);
		if (ok && !hi)
			check(rx & mask, (ex >> 1) & mask);
	endtask
	// =============================================================
	// Scenarios
	// =============================================================
	task automatic t_one_byte;
		run(16'h00C5, 8, 1'b1);
		run(16'h003A, 8, 1'b1);
	endtask
	task automatic t_two_byte;
		run(16'hA53C, 16, 1'b1);
	endtask
	task automatic t_idle_low;
		run(16'h0081, 8, 1'b0);
		run(16'h0FF1, 16, 1'b0);
	endtask
	task automatic t_refused;
		run(16'h0ABC, 12, 1'b1);
		run(16'h01FF, 9, 1'b0);
	endtask
	task automatic t_deselect;
		i_hscp_host.toggle(6);
		wait_valid(1'b0);
		check(cmd_word, last);
		run(16'h0096, 8, 1'b1);
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		t_one_byte;
		t_two_byte;
		t_idle_low;
		t_refused;
		t_deselect;
		summarize;
	end
endmodule
